/* rtl/tmr_pkg.sv */
// Package of register map, field positions, reset values and timing counts
// Function
// - Source select clear: timer mode, count every instruction cycle without prescaler
// - Software write to count register suppresses counting for two instruction cycles
// - Source select set: counter mode, count edges of external count input
// - Edge select clear counts rising edges, set counts falling edges
// - Scaler assign clear gives prescaler to timer, set gives it to watchdog
// - Assign bit and ratio field set prescaler assignment and ratio
// - Overflow flag sets when count rolls from maximum to zero
// - Timer interrupt request only while overflow interrupt enable is set
// - Overflow flag stays set until software clears it
// - Timer stops counting during sleep
// - External source synchronised by sampling at second and fourth phase clocks
// - Prescaler divides external input as a ripple counter, symmetrical output
// - Count advances some cycles after the external edge, not at it
// - One 8-bit scaler; whoever lacks it runs undivided
// - Timer-assigned prescaler clears on every write to count register
// - Watchdog-assigned prescaler clears on watchdog clear instruction
// - Software cannot read or write the prescaler count
`default_nettype none
package tmr_pkg;
  // Register indices and byte addresses
  localparam logic [7:0] count_register_idx = 8'h01;
  localparam logic [7:0] irq_control_register_idx = 8'h0b;
  localparam logic [7:0] timer_and_port_options_idx = 8'h81;
  localparam logic [7:0] control_status_idx = 8'h90;
  localparam logic [11:0] count_register_addr = {2'h0, count_register_idx, 2'h0};
  localparam logic [11:0] irq_control_addr = {2'h0, irq_control_register_idx, 2'h0};
  localparam logic [11:0] options_addr = {2'h0, timer_and_port_options_idx, 2'h0};
  localparam logic [11:0] control_status_addr = {2'h0, control_status_idx, 2'h0};
  // Option fields
  localparam int count_source_select_bit = 5;
  localparam int count_edge_select_bit = 4;
  localparam int scaler_assign_bit = 3;
  localparam int scale_ratio_lsb = 0;
  // Interrupt control fields
  localparam int overflow_irq_enable_bit = 5;
  localparam int overflow_flag_bit = 2;
  // Control/status fields
  localparam int sleep_bit = 0;
  localparam int wdt_clear_bit = 1;
  // Reset values
  localparam logic [7:0] options_reset = 8'hff;
  localparam logic [7:0] irq_control_reset = 8'h00;
  localparam logic [7:0] count_reset = 8'h00;
  // Timing
  localparam int clock_ns = 100;
  localparam int instr_ns = 400;
  localparam int phases_per_cycle = instr_ns / clock_ns;
  localparam int write_inhibit_cycles = 2;
  typedef enum logic [1:0] {
    ph_q1 = 2'b00,
    ph_q2 = 2'b01,
    ph_q3 = 2'b10,
    ph_q4 = 2'b11
  } phase_e;
endpackage
`default_nettype wire

/* rtl/scaler_if.sv */
// Interface between timer core and shared scaler
`default_nettype none
interface scaler_if;
  logic src_edge;
  logic clear;
  logic [7:0] count;
  modport core (output src_edge, output clear, input count);
  modport scaler (input src_edge, input clear, output count);
endinterface
`default_nettype wire

/* rtl/shared_scaler.sv */
// Shared 8-bit ripple-style scaler counter
`default_nettype none
module shared_scaler #(
  parameter int width = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core side
  scaler_if.scaler sc
);
  logic [width-1:0] stage;
  // Binary count; each bit toggles on fall of the one below, as a ripple chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= '0;
    end else if (sc.clear) begin
      stage <= '0;
    end else if (sc.src_edge) begin
      stage <= stage + 1'b1;
    end
  end
  assign sc.count = stage;
endmodule // shared_scaler
`default_nettype wire

/* rtl/timer0_with_shared_prescaler.sv */
// Timer/counter with shared prescaler, APB slave
//
// Added by the designer: register access over APB.
`default_nettype none
module timer0_with_shared_prescaler
  import tmr_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and watchdog side
  input wire logic external_count_input,
  input wire logic wdt_tick,
  output logic timer_irq,
  output logic wdt_scaled_tick,
  output logic wdt_counter_clear
);
  scaler_if sc ();
  shared_scaler #(.width(8)) u_scaler (.pclk(pclk), .presetn(presetn), .sc(sc));

  logic [7:0] options;
  logic [7:0] count_register;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic sleep_mode;
  logic [1:0] inhibit;
  logic [1:0] phase;
  logic pin_sync;
  logic pin_prev;
  logic tap;
  logic tap_q;
  logic tap_samp;
  logic instr_tick;
  logic samp_strobe;
  logic inc;
  logic acc;
  logic wr;
  logic wr_count;
  logic wdt_clr;
  logic timer_owns;
  logic src_edge;
  logic [7:0] next_count;
  logic [31:0] next_rdata;

  // Bit of the scaler counter that marks a given division
  function automatic logic tap_bit(input logic [7:0] cnt, input logic [2:0] sel);
    tap_bit = cnt[sel];
  endfunction

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign wr_count = wr && (paddr == count_register_addr);
  assign wdt_clr = wr && (paddr == control_status_addr) && pwdata[wdt_clear_bit];
  assign timer_owns = !options[scaler_assign_bit];
  assign instr_tick = (phase == 2'(ph_q4));
  assign samp_strobe = (phase == 2'(ph_q2)) || (phase == 2'(ph_q4));

  // Phase counter: four clocks per instruction cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // External pin edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_sync <= external_count_input;
      pin_prev <= pin_sync;
    end
  end

  // Scaler source: selected pin edge or instruction cycle; watchdog tick if watchdog owns it
  always_comb begin
    if (!timer_owns) begin
      src_edge = wdt_tick;
    end else if (options[count_source_select_bit]) begin
      if (options[count_edge_select_bit]) begin
        src_edge = pin_prev && !pin_sync;
      end else begin
        src_edge = !pin_prev && pin_sync;
      end
    end else begin
      src_edge = instr_tick && !sleep_mode;
    end
  end
  assign sc.src_edge = src_edge && !sleep_mode;
  assign sc.clear = (wr_count && timer_owns) || (wdt_clr && !timer_owns);

  // Scaler output: ratio 2^(n+1) for timer, the pin itself when unassigned
  // Counted event is a fall of tap except in timer mode without prescaler, so a rising pin edge is inverted
  always_comb begin
    if (timer_owns) begin
      tap = tap_bit(sc.count, options[2:0]);
    end else if (options[count_edge_select_bit]) begin
      tap = pin_sync;
    end else begin
      tap = !pin_sync;
    end
  end

  // Sampled at second and fourth phases before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_samp <= 1'b0;
      tap_q <= 1'b0;
    end else if (phase == 2'(ph_q2) || phase == 2'(ph_q4)) begin
      tap_samp <= tap;
      tap_q <= tap_samp;
    end
  end

  // Increment source; each pair of consecutive samples is judged once
  always_comb begin
    if (!options[count_source_select_bit] && !timer_owns) begin
      inc = instr_tick;
    end else begin
      inc = samp_strobe && tap_q && !tap_samp;
    end
  end

  // Count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_register <= count_reset;
      inhibit <= 2'h0;
    end else if (wr_count) begin
      count_register <= pwdata[7:0];
      inhibit <= 2'(write_inhibit_cycles);
    end else begin
      if (instr_tick && inhibit != 2'h0) begin
        inhibit <= inhibit - 2'h1;
      end
      if (inc && !sleep_mode && inhibit == 2'h0) begin
        count_register <= count_register + 8'h01;
      end
    end
  end

  // Overflow flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (inc && !sleep_mode && !wr_count && inhibit == 2'h0
                 && count_register == 8'hff) begin
      overflow_flag <= 1'b1;
    end else if (wr && paddr == irq_control_addr) begin
      overflow_flag <= pwdata[overflow_flag_bit];
    end
  end

  // Option, enable and sleep registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      options <= options_reset;
      overflow_irq_enable <= 1'b0;
      sleep_mode <= 1'b0;
    end else if (wr) begin
      if (paddr == options_addr) begin
        options <= pwdata[7:0];
      end
      if (paddr == irq_control_addr) begin
        overflow_irq_enable <= pwdata[overflow_irq_enable_bit];
      end
      if (paddr == control_status_addr) begin
        sleep_mode <= pwdata[sleep_bit];
      end
    end
  end

  // Watchdog postscaler output: ratio 2^n, undivided when timer owns scaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_scaled_tick <= 1'b0;
      wdt_counter_clear <= 1'b0;
    end else begin
      wdt_counter_clear <= wdt_clr;
      if (timer_owns) begin
        wdt_scaled_tick <= wdt_tick;
      end else if (options[2:0] == 3'h0) begin
        wdt_scaled_tick <= wdt_tick;
      end else begin
        wdt_scaled_tick <= wdt_tick && (sc.count[options[2:0] - 3'h1 +: 1] == 1'b1)
          && ((sc.count & ((8'h01 << options[2:0]) - 8'h01)) == ((8'h01 << options[2:0])
          - 8'h01));
      end
    end
  end

  // Interrupt request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= overflow_flag && overflow_irq_enable;
    end
  end

  // Read mux; prescaler itself has no address
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      count_register_addr: next_rdata = {24'h0, count_register};
      irq_control_addr: next_rdata = {26'h0, overflow_irq_enable, 2'h0, overflow_flag, 2'h0};
      options_addr: next_rdata = {24'h0, options};
      control_status_addr: next_rdata = {31'h0, sleep_mode};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // APB answer: no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == count_register_addr
        || paddr == irq_control_addr || paddr == options_addr
        || paddr == control_status_addr);
      if (psel && !penable && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end
endmodule // timer0_with_shared_prescaler
`default_nettype wire

/* tb/tmr_monitor.sv */
// Checker of port-level timer behaviour
`default_nettype none
module tmr_monitor
  import tmr_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and watchdog side
  input wire logic external_count_input,
  input wire logic wdt_tick,
  input wire logic timer_irq,
  input wire logic wdt_scaled_tick,
  input wire logic wdt_counter_clear
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] opt, irqc;
  wire wr = psel && penable && pready && pwrite;
  wire clr = wr && paddr == control_status_addr && pwdata[wdt_clear_bit];
  wire mapped = paddr inside {count_register_addr, irq_control_addr, options_addr,
    control_status_addr};
  // Shadow of written options and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt <= options_reset;
      irqc <= irq_control_reset;
    end else if (wr && paddr == options_addr) begin
      opt <= pwdata[7:0];
    end else if (wr && paddr == irq_control_addr) begin
      irqc <= pwdata[7:0];
    end
  end
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  a_ready_after_setup: assert property (setup_s |=> access_s ##0 pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> access_s) else $error("stray ready");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped) else $error("bad slverr");
  a_unmapped_reads_zero: assert property (pready && !mapped && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_when_masked: assert property (!irqc[overflow_irq_enable_bit] [*2] |-> !timer_irq)
    else $error("irq while masked");
  a_wdt_clear_follows: assert property (clr |-> ##[1:2] wdt_counter_clear)
    else $error("no watchdog clear");
  a_wdt_undivided: assert property ((!opt[3] || opt[2:0] == 3'h0) && wdt_tick
    |-> ##[0:2] wdt_scaled_tick) else $error("watchdog tick lost");
  a_scaled_has_cause: assert property (wdt_scaled_tick
    |-> wdt_tick || $past(wdt_tick) || $past(wdt_tick, 2)) else $error("stray scaled tick");
endmodule // tmr_monitor
bind timer0_with_shared_prescaler tmr_monitor mon (.*);
`default_nettype wire

/* tb/ext_source.sv */
// External count source on the count input pin
`default_nettype none
module ext_source #(
  parameter int half = 24
) (
  // Control from bench
  input wire logic pclk,
  input wire logic [7:0] pulses,
  input wire logic go,
  // Pin
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle low between bursts
  initial line = 1'b0;
  always @(posedge go) begin
    repeat (pulses) begin
      repeat (half) @(posedge pclk);
      line <= 1'b1;
      repeat (half) @(posedge pclk);
      line <= 1'b0;
    end
  end
endmodule // ext_source
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the timer block
`default_nettype none
module tb_top
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wdt_tick = 0, go = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, timer_irq, wdt_scaled_tick, wdt_counter_clear, err;
  logic external_count_input;
  logic [7:0] pulses = 0;
  int failures = 0, checked = 0, cyc = 0, ticks = 0, clears = 0;
  timer0_with_shared_prescaler DUT (.*);
  ext_source src (.pclk, .pulses, .go, .line(external_count_input));
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (wdt_scaled_tick === 1'b1) ticks++;
    if (wdt_counter_clear === 1'b1) clears++;
    if (cyc == 40000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic t_reset();
    rc(options_addr, 32'hff);
    rc(count_register_addr, 32'h0);
    rc(irq_control_addr, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk(err, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_timer();
    int n;
    apb(1'b1, options_addr, 32'h08);
    apb(1'b1, count_register_addr, 32'hfe);
    rc(count_register_addr, 32'hfe);
    apb(1'b1, irq_control_addr, 32'h20);
    n = 0;
    while (timer_irq !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    chk(timer_irq, 1'b1);
    rc(irq_control_addr, 32'h24);
    apb(1'b1, irq_control_addr, 32'h04);
    wc(2);
    chk(timer_irq, 1'b0);
    rc(irq_control_addr, 32'h04);
    apb(1'b1, irq_control_addr, 32'h0);
    rc(irq_control_addr, 32'h0);
    $display("test timer done");
  endtask
  task automatic t_ratio();
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, options_addr, k);
      apb(1'b1, count_register_addr, 32'h0);
      wc(32 << (k + 1));
      apb(1'b0, count_register_addr, 32'h0);
      chk(rd >= 6 && rd <= 8, 1'b1);
    end
    $display("test ratio done");
  endtask
  task automatic tc(input logic [7:0] m, input logic [7:0] p, input int w, input logic [7:0] e);
    wc(40);
    apb(1'b1, options_addr, m);
    apb(1'b1, count_register_addr, 32'h0);
    wc(4);
    pulses <= p;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    wc(w);
    rc(count_register_addr, e);
  endtask
  task automatic t_counter();
    tc(8'h28, 8'd3, 130, 8'd3);
    tc(8'h38, 8'd3, 130, 8'd2);
    tc(8'h20, 8'd6, 300, 8'd3);
    $display("test counter done");
  endtask
  task automatic t_sleep();
    apb(1'b1, options_addr, 32'h08);
    apb(1'b1, count_register_addr, 32'h10);
    apb(1'b1, control_status_addr, 32'h1);
    wc(40);
    rc(count_register_addr, 32'h10);
    apb(1'b1, control_status_addr, 32'h0);
    wc(40);
    apb(1'b0, count_register_addr, 32'h0);
    chk(rd[7:0] > 8'h10, 1'b1);
    $display("test sleep done");
  endtask
  task automatic t_wdt();
    logic [7:0] opts [4] = '{8'h00, 8'h08, 8'h09, 8'h0b};
    foreach (opts[i]) begin
      clears = 0;
      apb(1'b1, count_register_addr, 32'h0);
      apb(1'b1, control_status_addr, 32'h2);
      apb(1'b1, options_addr, opts[i]);
      apb(1'b1, control_status_addr, 32'h2);
      wc(2);
      chk(clears, 2);
      ticks = 0;
      repeat (8) begin
        @(posedge pclk) wdt_tick <= 1'b1;
        @(posedge pclk) wdt_tick <= 1'b0;
        wc(2);
      end
      wc(4);
      chk(ticks, opts[i][3] ? 8 >> opts[i][2:0] : 8);
    end
    $display("test watchdog done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_timer();
    t_ratio();
    t_counter();
    t_sleep();
    t_wdt();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
